// *** src/seq_entry_mem.sv ***
// Storage of the four stack entries with two registered read ports
`timescale 1ns/1ps
`include "seq_stack_map.svh"
module seq_entry_mem
  import seq_stack_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire entry_idx_t wr_idx_i,
  input wire entry_bits_t wr_data_i,
  input wire entry_idx_t rd_idx_i,
  output entry_bits_t rd_data_o,
  input wire entry_idx_t seq_idx_i,
  output entry_bits_t seq_data_o
);

  entry_bits_t mem_r [`SEQ_ENTRY_COUNT];
  entry_bits_t mem_nxt [`SEQ_ENTRY_COUNT];
  entry_bits_t rd_r;
  entry_bits_t rd_nxt;
  entry_bits_t seq_r;
  entry_bits_t seq_nxt;

  function automatic entry_bits_t reset_bits(input int idx);
    logic [15:0] word;
    begin
      case (idx)
        0: word = `SEQ_RST_ENTRY_ZERO;
        1: word = `SEQ_RST_ENTRY_ONE;
        2: word = `SEQ_RST_ENTRY_TWO;
        default: word = `SEQ_RST_ENTRY_THREE;
      endcase
      reset_bits = word[8:0];
    end
  endfunction : reset_bits

  genvar gi;
  generate
    for (gi = 0; gi < `SEQ_ENTRY_COUNT; gi++) begin : g_entry
      always_comb begin
        mem_nxt[gi] = mem_r[gi];
        if (we_i && (wr_idx_i == entry_idx_t'(gi))) begin
          mem_nxt[gi] = wr_data_i;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          mem_r[gi] <= reset_bits(gi);
        end else begin
          mem_r[gi] <= mem_nxt[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_nxt = mem_r[rd_idx_i];
    seq_nxt = mem_r[seq_idx_i];
  end

  // Both ports restart on entry zero, the entry the sequencer starts from
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_r <= reset_bits(0);
      seq_r <= reset_bits(0);
    end else begin
      rd_r <= rd_nxt;
      seq_r <= seq_nxt;
    end
  end

  assign rd_data_o = rd_r;
  assign seq_data_o = seq_r;

endmodule : seq_entry_mem

// *** src/seq_pin_sync.sv ***
// Three-stage synchroniser and edge filter for the conversion-done pin
`timescale 1ns/1ps
module seq_pin_sync (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o
);

  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic level_r;
  logic level_nxt;
  logic rise_r;
  logic rise_nxt;

  // Stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
  always_comb begin
    stage_nxt = {stage_r[1:0], pin_i};
    level_nxt = level_r;
    rise_nxt = 1'b0;
    if (stage_r[1] == stage_r[2]) begin
      level_nxt = stage_r[2];
      rise_nxt = stage_r[2] & ~level_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      stage_r <= 3'h0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise_o = rise_r;

endmodule : seq_pin_sync

// *** src/seq_stack_map.svh ***
// Address map, field positions, reset values and timing of the sequence stack
`ifndef SEQ_STACK_MAP_SVH
`define SEQ_STACK_MAP_SVH

// ******************************************************
// Register indices (byte address is four times the index)
// ******************************************************
`define SEQ_IDX_ENTRY_ZERO 6'h20
`define SEQ_IDX_ENTRY_ONE 6'h21
`define SEQ_IDX_ENTRY_TWO 6'h22
`define SEQ_IDX_ENTRY_THREE 6'h23
`define SEQ_IDX_STATUS 6'h30

// ******************************************************
// Byte addresses on the bus
// ******************************************************
`define SEQ_ADDR_ENTRY_BASE 8'h80
`define SEQ_ADDR_STATUS 8'hC0

// ******************************************************
// Field positions inside an entry word
// ******************************************************
`define SEQ_BIT_WRITE_SEL 15
`define SEQ_ADDR_FIELD_MSB 14
`define SEQ_ADDR_FIELD_LSB 9
`define SEQ_BIT_STACK_RETURN 8
`define SEQ_CHAN_B_MSB 7
`define SEQ_CHAN_B_LSB 4
`define SEQ_CHAN_A_MSB 3
`define SEQ_CHAN_A_LSB 0

// ******************************************************
// Reset values
// ******************************************************
`define SEQ_RST_ENTRY_ZERO 16'h4000
`define SEQ_RST_ENTRY_ONE 16'h4211
`define SEQ_RST_ENTRY_TWO 16'h4422
`define SEQ_RST_ENTRY_THREE 16'h4633

// ******************************************************
// Sizes and timing
// ******************************************************
`define SEQ_ENTRY_COUNT 4
`define SEQ_LAST_ENTRY 2'h3
`define SEQ_STORED_BITS 9
`define SEQ_SYNC_STAGES 3
`define SEQ_ANSWER_CYCLES 2

`endif

// *** src/seq_stack_pkg.sv ***
// Types shared by the sequence stack files
package seq_stack_pkg;

  // Bus slave states, Gray coded along idle -> fetch -> answer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_ANSWER = 2'b11
  } bus_state_t;

  typedef logic [1:0] entry_idx_t;
  typedef logic [8:0] entry_bits_t;

endpackage : seq_stack_pkg

// *** src/seq_stack_regs.sv ***
// Sequence stack entries behind an APB slave, with the stack sequencer
//
// How it works
// R1 - Bit 15 set writes entry, clear reads
// R2 - Bits 14-9 must hold entry's own address
// R3 - Return bit clear: step to next entry
// R4 - Return bit set: go back to first
// R5 - Bits 7-4 pick converter B channel
// R6 - Bits 3-0 pick converter A channel
// R7 - Entry one at 0x21, resets 0x4211
// R8 - Entry two at 0x22, resets 0x4422
// R9 - Entry three at 0x23, resets 0x4633
// R10 - Entry zero at 0x20, resets 0x4000
// R11 - Next means next address; last wraps
`timescale 1ns/1ps
`include "seq_stack_map.svh"
module seq_stack_regs
  import seq_stack_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic conv_done_pin_i,
  output logic [3:0] conv_a_channel_o,
  output logic [3:0] conv_b_channel_o,
  output logic [1:0] active_entry_o
);

  // ******************************************************
  // Bus slave
  // ******************************************************
  bus_state_t state_r;
  bus_state_t state_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic wr_ok_r;
  logic wr_ok_nxt;
  entry_idx_t active_r;
  entry_idx_t active_nxt;
  entry_bits_t rd_bits;
  entry_bits_t seq_bits;
  entry_idx_t bus_idx;
  logic [5:0] own_addr;
  logic hit_entry;
  logic hit_status;
  logic mem_we;
  logic done_evt;

  assign bus_idx = paddr_i[3:2];
  assign hit_entry = (paddr_i[7:4] == 4'(`SEQ_ADDR_ENTRY_BASE >> 4)) &&
                     (paddr_i[1:0] == 2'h0);
  assign hit_status = (paddr_i == `SEQ_ADDR_STATUS);

  // Address field value each entry answers to
  always_comb begin
    case (bus_idx)
      2'h0: own_addr = `SEQ_IDX_ENTRY_ZERO; // R10
      2'h1: own_addr = `SEQ_IDX_ENTRY_ONE; // R7
      2'h2: own_addr = `SEQ_IDX_ENTRY_TWO; // R8
      default: own_addr = `SEQ_IDX_ENTRY_THREE; // R9
    endcase
  end

  // Read data is fetched in the first access cycle, answered in the second
  always_comb begin
    state_nxt = state_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    wr_ok_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (psel_i && !penable_i) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        state_nxt = ST_ANSWER;
        pready_nxt = 1'b1;
        prdata_nxt = 32'h0000_0000;
        if (hit_entry) begin
          // The select bit always reads back as zero
          prdata_nxt[`SEQ_ADDR_FIELD_MSB:`SEQ_ADDR_FIELD_LSB] = own_addr;
          prdata_nxt[8:0] = rd_bits;
          if (pwrite_i) begin
            if (pwdata_i[`SEQ_BIT_WRITE_SEL] && // R1
                (pwdata_i[`SEQ_ADDR_FIELD_MSB:`SEQ_ADDR_FIELD_LSB] ==
                 own_addr)) begin // R2
              wr_ok_nxt = 1'b1;
            end else begin
              pslverr_nxt = 1'b1;
            end
          end
        end else if (hit_status && !pwrite_i) begin
          prdata_nxt[1:0] = active_r;
        end else begin
          pslverr_nxt = 1'b1;
        end
      end
      ST_ANSWER: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      wr_ok_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      wr_ok_r <= wr_ok_nxt;
    end
  end

  // The write lands on the edge where the master sees pready
  assign mem_we = (state_r == ST_ANSWER) && wr_ok_r; // R1

  // ******************************************************
  // Entry storage and pin input
  // ******************************************************
  seq_entry_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(mem_we),
    .wr_idx_i(bus_idx),
    .wr_data_i(pwdata_i[8:0]),
    .rd_idx_i(bus_idx),
    .rd_data_o(rd_bits),
    .seq_idx_i(active_r),
    .seq_data_o(seq_bits)
  );

  seq_pin_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(conv_done_pin_i),
    .rise_o(done_evt)
  );

  // ******************************************************
  // Sequencer
  // ******************************************************
  // The active entry's bits lag a step by one cycle; conversions are far
  // longer than that, so a done event never meets stale bits in practice.
  always_comb begin
    active_nxt = active_r;
    if (done_evt) begin
      if (seq_bits[`SEQ_BIT_STACK_RETURN]) begin
        active_nxt = 2'h0; // R4
      end else if (active_r == `SEQ_LAST_ENTRY) begin
        active_nxt = 2'h0; // R11
      end else begin
        active_nxt = active_r + 2'h1; // R3
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      active_r <= 2'h0;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign conv_a_channel_o = seq_bits[`SEQ_CHAN_A_MSB:`SEQ_CHAN_A_LSB]; // R6
  assign conv_b_channel_o = seq_bits[`SEQ_CHAN_B_MSB:`SEQ_CHAN_B_LSB]; // R5
  assign active_entry_o = active_r;

  // ******************************************************
  // Assertions
  // ******************************************************
  a_ready_after_two: assert property ( // R2
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_IDLE && psel_i && !penable_i) |=>
      !pready_o ##1 pready_o ##1 !pready_o)
    else $error("pready not on second access cycle");

  a_unmapped_error: assert property ( // R10
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_FETCH && !hit_entry && !hit_status) |=> pslverr_o)
    else $error("unmapped address not refused");

  a_select_bit_write: assert property ( // R1
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_FETCH && hit_entry && pwrite_i &&
     !pwdata_i[`SEQ_BIT_WRITE_SEL]) |=> pslverr_o && pready_o && !mem_we)
    else $error("write without select bit accepted");

  a_addr_field_match: assert property ( // R2
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_FETCH && hit_entry && pwrite_i &&
     pwdata_i[`SEQ_BIT_WRITE_SEL] &&
     pwdata_i[`SEQ_ADDR_FIELD_MSB:`SEQ_ADDR_FIELD_LSB] == own_addr) |=>
      !pslverr_o && pready_o && mem_we)
    else $error("matching write not performed");

  a_step_next: assert property ( // R3
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (done_evt && !seq_bits[`SEQ_BIT_STACK_RETURN] &&
     active_r != `SEQ_LAST_ENTRY) |=>
      active_entry_o == $past(active_r) + 2'h1)
    else $error("sequencer did not step forward");

  a_return_first: assert property ( // R4
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (done_evt && seq_bits[`SEQ_BIT_STACK_RETURN]) |=>
      active_entry_o == 2'h0)
    else $error("sequencer did not return to first entry");

  a_wrap_last: assert property ( // R11
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (done_evt && active_r == `SEQ_LAST_ENTRY) |=> active_entry_o == 2'h0)
    else $error("sequencer did not wrap after last entry");

  a_reset_start: assert property ( // R10
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !$past(rst_n_i) |->
      active_entry_o == 2'h0 && conv_a_channel_o == 4'h0 &&
      conv_b_channel_o == 4'h0)
    else $error("sequencer not on entry zero after reset");

  a_hold_no_event: assert property ( // R6
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !done_evt |=> $stable(active_entry_o))
    else $error("active entry moved without a done event");

  a_read_own_field: assert property ( // R2
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_FETCH && hit_entry) |=>
      !prdata_o[`SEQ_BIT_WRITE_SEL] &&
      prdata_o[`SEQ_ADDR_FIELD_MSB:`SEQ_ADDR_FIELD_LSB] == $past(own_addr))
    else $error("entry read without its own address field");

  a_unmapped_zero: assert property ( // R2
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_FETCH && !hit_entry && !hit_status) |=>
      prdata_o == 32'h0000_0000)
    else $error("unmapped address returned data");

  a_status_no_write: assert property ( // R1
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_FETCH && hit_status && pwrite_i) |=>
      pslverr_o && pready_o && !mem_we)
    else $error("write to status register accepted");

  a_status_active: assert property ( // R3
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_FETCH && hit_status && !pwrite_i) |=>
      !pslverr_o && prdata_o == {30'h0000_0000, $past(active_r)})
    else $error("status read did not show the active entry");

  a_addr_mismatch: assert property ( // R2
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == ST_FETCH && hit_entry && pwrite_i &&
     pwdata_i[`SEQ_BIT_WRITE_SEL] &&
     pwdata_i[`SEQ_ADDR_FIELD_MSB:`SEQ_ADDR_FIELD_LSB] != own_addr) |=>
      pslverr_o && pready_o && !mem_we)
    else $error("write with a foreign address field accepted");

  a_error_has_ready: assert property ( // R1
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    pslverr_o |-> pready_o)
    else $error("error flag raised outside an answer");

  a_done_single: assert property ( // R3
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_evt |=> !done_evt)
    else $error("one pin pulse made two done events");

  // The new word reaches the channel outputs one edge after it lands
  a_chan_a_write: assert property ( // R6
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (mem_we && bus_idx == active_r && !done_evt) |-> ##2
      conv_a_channel_o ==
        $past(pwdata_i[`SEQ_CHAN_A_MSB:`SEQ_CHAN_A_LSB], 2))
    else $error("write to active entry missed channel A");

  a_chan_b_write: assert property ( // R5
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (mem_we && bus_idx == active_r && !done_evt) |-> ##2
      conv_b_channel_o ==
        $past(pwdata_i[`SEQ_CHAN_B_MSB:`SEQ_CHAN_B_LSB], 2))
    else $error("write to active entry missed channel B");

endmodule : seq_stack_regs

// *** verification/seq_host_model.sv ***
// Host controller model: APB master and conversion-done pin driver
`timescale 1ns/1ps
module seq_host_model (
  input wire logic clk_i,
  input wire logic pready_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic done_pin_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
    done_pin_o = 1'b0;
  end

  // ****************
  // Bus transfer
  // ****************
  // One edge passes first, so psel never gets two values in one step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released data must not look like the last request
    pwdata_o <= ~d;
  endtask : xfer

  // Pin held high and low long enough for the three-flop filter
  task automatic conv_pulse();
    @(posedge clk_i);
    done_pin_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    done_pin_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : conv_pulse
endmodule : seq_host_model

// *** verification/seq_stack_regs_tb.sv ***
// Self-checking testbench of the sequence stack register block
`timescale 1ns/1ps
module seq_stack_regs_tb;
  logic ref_clk_i;
  logic rst_n_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic conv_done_pin_i;
  logic [3:0] conv_a_channel_o;
  logic [3:0] conv_b_channel_o;
  logic [1:0] active_entry_o;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [8:0] mem [4];
  int fails;
  int checked;

  seq_host_model u_host (
    .clk_i(ref_clk_i),
    .pready_i(pready_o),
    .psel_o(psel_i),
    .penable_o(penable_i),
    .pwrite_o(pwrite_i),
    .paddr_o(paddr_i),
    .pwdata_o(pwdata_i),
    .done_pin_o(conv_done_pin_i)
  );

  seq_stack_regs DUT (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .conv_done_pin_i(conv_done_pin_i),
    .conv_a_channel_o(conv_a_channel_o),
    .conv_b_channel_o(conv_b_channel_o),
    .active_entry_o(active_entry_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // ****************
  // Answer monitor
  // ****************
  // Writes carry no read data, so only the error flag is compared
  always @(posedge ref_clk_i) begin
    if (pready_o === 1'b1) begin
      if (notes.size() == 0) begin
        check(33'd1, 33'd0);
      end else begin
        note = notes.pop_front();
        if (note[33]) begin
          check({pslverr_o, prdata_o}, note[32:0]);
        end else begin
          check({pslverr_o, 32'h0}, {note[32], 32'h0});
        end
      end
    end
  end

  // Entry word image: direction bit, own index, stored bits
  function automatic logic [31:0] img(input logic w, input logic [1:0] i,
                                      input logic [8:0] b);
    return {16'h0000, w, 4'h8, i, b};
  endfunction : img

  task automatic rd(input logic [7:0] a, input logic e, input logic [31:0] d);
    notes.push_back({1'b1, e, d});
    u_host.xfer(1'b0, a, $urandom);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic e, input logic [31:0] d);
    notes.push_back({1'b0, e, 32'h0000_0000});
    u_host.xfer(1'b1, a, d);
  endtask : wr

  task automatic step(input logic [1:0] nxt);
    u_host.conv_pulse();
    check({31'h0, active_entry_o}, {31'h0, nxt});
    check({25'h0, conv_b_channel_o, conv_a_channel_o},
          {25'h0, mem[nxt][7:0]});
    rd(8'hC0, 1'b0, {30'h0, nxt});
  endtask : step

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    rst_n_i = 1'b0;
    fails = 0;
    checked = 0;
    void'($urandom(32'h98ff3fd6));
    mem[0] = 9'h000;
    mem[1] = 9'h011;
    mem[2] = 9'h022;
    mem[3] = 9'h033;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    check({31'h0, active_entry_o}, 33'h0_0000_0000);
    for (int i = 0; i < 4; i++) begin
      rd(8'h80 + 8'(i * 4), 1'b0, img(1'b0, 2'(i), mem[i]));
    end
    $display("Test reset values done");
    rd(8'h90, 1'b1, 32'h0000_0000);
    rd(8'h85, 1'b1, 32'h0000_0000);
    wr(8'hC0, 1'b1, 32'h0000_0000);
    wr(8'h84, 1'b1, img(1'b0, 2'd1, 9'h0aa));
    wr(8'h84, 1'b1, {16'h0000, 1'b1, 6'h22, 9'h0aa});
    rd(8'h84, 1'b0, img(1'b0, 2'd1, mem[1]));
    $display("Test refused accesses done");
    for (int i = 0; i < 4; i++) begin
      mem[i] = {1'b0, 8'($urandom)};
      wr(8'h80 + 8'(i * 4), 1'b0, img(1'b1, 2'(i), mem[i]));
      rd(8'h80 + 8'(i * 4), 1'b0, img(1'b0, 2'(i), mem[i]));
    end
    $display("Test random contents done");
    step(2'd1);
    step(2'd2);
    step(2'd3);
    step(2'd0);
    $display("Test sequencer stepping done");
    mem[1][8] = 1'b1;
    wr(8'h84, 1'b0, img(1'b1, 2'd1, mem[1]));
    step(2'd1);
    step(2'd0);
    $display("Test stack return done");
    repeat (4) @(posedge ref_clk_i);
    complete_run();
  end
endmodule : seq_stack_regs_tb
